// file: rtl/smdcr_regs.sv
// serial-controlled control/status register block with driver and regulator decode
`timescale 1ns/100ps
module smdcr_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic spi_clk,
    input wire logic chip_select_low,
    input wire logic data_in,
    output logic data_out,
    output logic data_out_oe,
    input wire smdcr_pkg::smdcr_fault_s fault_flags,
    input wire logic [21:0] fault_wakeup_status,
    input wire logic [21:0] link_watchdog_status,
    input wire logic wake_event,
    input wire logic cyclic_timer_a,
    input wire logic cyclic_timer_b,
    input wire logic pulse_input_a,
    input wire logic pulse_input_b,
    output smdcr_pkg::smdcr_ctrl0_s driver_regulator_control,
    output logic [21:0] wake_timer_control,
    output logic [21:0] input_config_control,
    output smdcr_pkg::smdcr_mode_e op_mode,
    output logic main_highside_on,
    output logic [1:0] relay_on,
    output logic reg_two_on,
    output logic [11:0] small_highside_config,
    output logic watchdog_trigger
);

    // ---------------- link domain (spi_clk) ----------------
    logic frame_open_q;
    logic [smdcr_pkg::CNT_W-1:0] bit_cnt_q;
    logic [smdcr_pkg::CNT_W-1:0] bit_cnt_d;
    logic [smdcr_pkg::FRAME_BITS-1:0] rx_q;
    logic [smdcr_pkg::DATA_BITS-1:0] tx_q;
    logic [smdcr_pkg::DATA_BITS-1:0] tx_d;
    logic [smdcr_pkg::DATA_BITS-1:0] tx_sel;
    logic tx_live_q;
    logic start_tgl_q;
    wire logic link_clr;

    // core-domain snapshots, frozen while the frame runs
    logic err_snap_q;
    logic [smdcr_pkg::DATA_BITS-1:0] stat0_snap_q;
    logic [smdcr_pkg::DATA_BITS-1:0] stat1_snap_q;

    // chip select high closes the frame without needing a clock edge
    assign link_clr = rst | chip_select_low;

    always_ff @(posedge spi_clk or posedge link_clr) begin
        if (link_clr) begin
            frame_open_q <= 1'b0;
        end else begin
            frame_open_q <= 1'b1;
        end
    end

    // flips once per clocked frame, so a bare select pulse cannot replay the held command
    always_ff @(posedge spi_clk or posedge rst) begin
        if (rst) begin
            start_tgl_q <= 1'b0;
        end else if (!frame_open_q) begin
            start_tgl_q <= !start_tgl_q;
        end
    end

    // saturating count so an over-long frame never wraps back to 24
    assign bit_cnt_d = !frame_open_q ? smdcr_pkg::CNT_ONE :
                       (bit_cnt_q == smdcr_pkg::CNT_OVER) ? smdcr_pkg::CNT_OVER :
                       bit_cnt_q + smdcr_pkg::CNT_ONE;

    // count and shift hold after the frame so the core can read them
    always_ff @(posedge spi_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_q <= smdcr_pkg::CNT_ZERO;
            rx_q <= {smdcr_pkg::FRAME_BITS{1'b0}};
        end else begin
            bit_cnt_q <= bit_cnt_d;
            rx_q <= {rx_q[smdcr_pkg::FRAME_BITS-2:0], data_in};
        end
    end

    // the address is complete after the second rising edge
    assign tx_sel = (rx_q[smdcr_pkg::ADDR_BITS-1:0] == smdcr_pkg::ADDR_CTRL0) ? stat0_snap_q :
                    (rx_q[smdcr_pkg::ADDR_BITS-1:0] == smdcr_pkg::ADDR_CTRL1) ? stat1_snap_q :
                    smdcr_pkg::WORD_ZERO;
    assign tx_d = (bit_cnt_q == smdcr_pkg::CNT_ADDR_DONE) ? tx_sel :
                  {tx_q[smdcr_pkg::DATA_BITS-2:0], 1'b0};

    // data out changes on the falling edge, half a period ahead of host sampling
    always_ff @(negedge spi_clk or posedge link_clr) begin
        if (link_clr) begin
            tx_q <= smdcr_pkg::WORD_ZERO;
            tx_live_q <= 1'b0;
        end else begin
            tx_q <= tx_d;
            tx_live_q <= frame_open_q && (bit_cnt_q >= smdcr_pkg::CNT_ADDR_DONE);
        end
    end

    // error bit leads the frame: it must stand before the first clock edge
    assign data_out = tx_live_q ? tx_q[smdcr_pkg::DATA_BITS-1] : err_snap_q;
    assign data_out_oe = !chip_select_low;

    // ---------------- core domain (core_clk) ----------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic pa_s1_q;
    logic pa_s2_q;
    logic pb_s1_q;
    logic pb_s2_q;
    logic st_s1_q;
    logic st_s2_q;
    logic seen_tgl_q;
    wire logic cs_rise;
    wire logic frame_new;
    wire logic frame_ok;
    wire logic [1:0] frame_addr;
    wire logic [smdcr_pkg::DATA_BITS-1:0] frame_data;
    wire logic wr_ctrl0;
    wire logic wr_ctrl1;
    wire logic wr_ctrl2;
    wire logic err_now;
    wire smdcr_pkg::smdcr_ctrl0_s ctrl0_new;

    smdcr_pkg::smdcr_ctrl0_s ctrl0_q;
    logic [smdcr_pkg::DATA_BITS-1:0] ctrl1_q;
    logic [smdcr_pkg::DATA_BITS-1:0] ctrl2_q;
    smdcr_pkg::smdcr_mode_e mode_q;
    smdcr_pkg::smdcr_mode_e mode_d;
    logic hs_on_q;
    logic [1:0] relay_q;
    logic reg2_q;
    logic wd_watchdog_toggle_q;
    wire logic hs_on_d;
    wire logic [1:0] relay_d;
    wire logic reg2_d;
    wire logic is_active;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            pa_s1_q <= 1'b0;
            pa_s2_q <= 1'b0;
            pb_s1_q <= 1'b0;
            pb_s2_q <= 1'b0;
            st_s1_q <= 1'b0;
            st_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= chip_select_low;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            pa_s1_q <= pulse_input_a;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= pulse_input_b;
            pb_s2_q <= pb_s1_q;
            st_s1_q <= start_tgl_q;
            st_s2_q <= st_s1_q;
        end
    end

    // remembers the frame-start toggle as seen at the last select rise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen_tgl_q <= 1'b0;
        end else if (cs_rise) begin
            seen_tgl_q <= st_s2_q;
        end
    end

    // link clock is idle once chip select is high, so count and shift are stable here
    assign cs_rise = cs_s2_q && !cs_s3_q;
    assign frame_new = (st_s2_q != seen_tgl_q);
    assign frame_ok = cs_rise && frame_new && (bit_cnt_q == smdcr_pkg::CNT_FRAME);
    assign frame_addr = rx_q[smdcr_pkg::FRAME_BITS-1:smdcr_pkg::DATA_BITS];
    assign frame_data = rx_q[smdcr_pkg::DATA_BITS-1:0];
    assign wr_ctrl0 = frame_ok && (frame_addr == smdcr_pkg::ADDR_CTRL0);
    assign wr_ctrl1 = frame_ok && (frame_addr == smdcr_pkg::ADDR_CTRL1);
    assign wr_ctrl2 = frame_ok && (frame_addr == smdcr_pkg::ADDR_CTRL2);
    assign ctrl0_new = smdcr_pkg::smdcr_ctrl0_s'(frame_data);

    assign err_now = |fault_flags;

    // snapshots only follow the sources while no frame runs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            err_snap_q <= 1'b0;
            stat0_snap_q <= smdcr_pkg::WORD_ZERO;
            stat1_snap_q <= smdcr_pkg::WORD_ZERO;
        end else if (cs_s2_q) begin
            err_snap_q <= err_now;
            stat0_snap_q <= fault_wakeup_status;
            stat1_snap_q <= link_watchdog_status;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl0_q <= smdcr_pkg::smdcr_ctrl0_s'(smdcr_pkg::CTRL_RESET);
            ctrl1_q <= smdcr_pkg::CTRL_RESET;
            ctrl2_q <= smdcr_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_q <= ctrl0_new;
            end
            if (wr_ctrl1) begin
                ctrl1_q <= frame_data;
            end
            if (wr_ctrl2) begin
                ctrl2_q <= frame_data;
            end
        end
    end

    // standby returns to active only through a wake event from the wake-up logic; reg-one standby can still move to battery standby by a write
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            smdcr_pkg::MODE_ACTIVE: begin
                if (wr_ctrl0 && ctrl0_new.bat_standby_request) begin
                    mode_d = smdcr_pkg::MODE_BAT_STANDBY;
                end else if (wr_ctrl0 && ctrl0_new.reg_one_standby_request) begin
                    mode_d = smdcr_pkg::MODE_REG1_STANDBY;
                end
            end
            smdcr_pkg::MODE_REG1_STANDBY: begin
                if (wake_event) begin
                    mode_d = smdcr_pkg::MODE_ACTIVE;
                end else if (wr_ctrl0 && ctrl0_new.bat_standby_request) begin
                    mode_d = smdcr_pkg::MODE_BAT_STANDBY;
                end
            end
            smdcr_pkg::MODE_BAT_STANDBY: begin
                if (wake_event) begin
                    mode_d = smdcr_pkg::MODE_ACTIVE;
                end
            end
            default: begin
                mode_d = smdcr_pkg::MODE_ACTIVE;
            end
        endcase
    end

    assign is_active = (mode_q == smdcr_pkg::MODE_ACTIVE);

    function automatic logic main_hs_decode(
        input logic [2:0] code,
        input logic active,
        input logic tmr_a,
        input logic tmr_b,
        input logic pwm_a,
        input logic pwm_b
    );
        logic on;
        on = 1'b0;
        unique case (code)
            smdcr_pkg::HS_OFF: on = 1'b0;
            smdcr_pkg::HS_ACTIVE: on = active;
            smdcr_pkg::HS_TIMER_A: on = tmr_a;
            smdcr_pkg::HS_TIMER_B: on = tmr_b;
            smdcr_pkg::HS_PULSE_A: on = pwm_a;
            smdcr_pkg::HS_PULSE_B: on = pwm_b;
            default: on = 1'b0;
        endcase
        return on;
    endfunction

    assign hs_on_d = main_hs_decode(ctrl0_q.main_highside_config, is_active,
        cyclic_timer_a, cyclic_timer_b, pa_s2_q, pb_s2_q);

    wire logic [1:0] relay_cfg = {ctrl0_q.relay_b_enable, ctrl0_q.relay_a_enable};
    for (genvar i = 0; i < 2; i++) begin : g_relay
        assign relay_d[i] = relay_cfg[i] && is_active;
    end

    wire logic [1:0] reg2_cfg = {ctrl0_q.reg_two_mode_hi, ctrl0_q.reg_two_mode_lo};
    assign reg2_d = (reg2_cfg == smdcr_pkg::REG2_ALWAYS) ||
                    ((reg2_cfg == smdcr_pkg::REG2_ACTIVE) && is_active) ||
                    ((reg2_cfg == smdcr_pkg::REG2_ACT_STBY1) &&
                     (mode_q != smdcr_pkg::MODE_BAT_STANDBY));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_q <= smdcr_pkg::MODE_ACTIVE;
            hs_on_q <= 1'b0;
            relay_q <= 2'h0;
            reg2_q <= 1'b0;
            wd_watchdog_toggle_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            hs_on_q <= hs_on_d;
            relay_q <= relay_d;
            reg2_q <= reg2_d;
            // one pulse per change of the toggle bit
            wd_watchdog_toggle_q <= wr_ctrl0 && (ctrl0_new.watchdog_toggle != ctrl0_q.watchdog_toggle);
        end
    end

    assign driver_regulator_control = ctrl0_q;
    assign wake_timer_control = ctrl1_q;
    assign input_config_control = ctrl2_q;
    assign op_mode = mode_q;
    assign main_highside_on = hs_on_q;
    assign relay_on = relay_q;
    assign reg_two_on = reg2_q;
    assign small_highside_config = ctrl0_q.small_highside_config;
    assign watchdog_trigger = wd_watchdog_toggle_q;

endmodule

// file: rtl/smdcr_pkg.sv
// constants, field layouts and carrier types of the serial control register block
package smdcr_pkg;

    // frame layout: two address bits first, then 22 data bits
    localparam int ADDR_BITS = 2;
    localparam int DATA_BITS = 22;
    localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
    localparam int CNT_W = 5;

    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 5'h02;
    localparam logic [CNT_W-1:0] CNT_FRAME = 5'h18;
    // one past a full frame marks a frame that ran too long
    localparam logic [CNT_W-1:0] CNT_OVER = 5'h19;

    localparam logic [1:0] ADDR_CTRL0 = 2'h0;
    localparam logic [1:0] ADDR_CTRL1 = 2'h1;
    localparam logic [1:0] ADDR_CTRL2 = 2'h2;

    localparam logic [DATA_BITS-1:0] WORD_ZERO = 22'h000000;
    localparam logic [DATA_BITS-1:0] CTRL_RESET = 22'h000000;

    // main high-side driver codes
    localparam logic [2:0] HS_OFF = 3'h0;
    localparam logic [2:0] HS_ACTIVE = 3'h1;
    localparam logic [2:0] HS_TIMER_A = 3'h2;
    localparam logic [2:0] HS_TIMER_B = 3'h3;
    localparam logic [2:0] HS_PULSE_A = 3'h4;
    localparam logic [2:0] HS_PULSE_B = 3'h5;

    // regulator-two mode codes
    localparam logic [1:0] REG2_OFF = 2'h0;
    localparam logic [1:0] REG2_ACTIVE = 2'h1;
    localparam logic [1:0] REG2_ACT_STBY1 = 2'h2;
    localparam logic [1:0] REG2_ALWAYS = 2'h3;

    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_REG1_STANDBY,
        MODE_BAT_STANDBY
    } smdcr_mode_e;

    // control register 0, bit 21 down to bit 0
    typedef struct packed {
        logic reg_one_standby_request;
        logic bat_standby_request;
        logic watchdog_toggle;
        logic reg_two_mode_hi;
        logic reg_two_mode_lo;
        logic relay_b_enable;
        logic relay_a_enable;
        logic [2:0] main_highside_config;
        logic [11:0] small_highside_config;
    } smdcr_ctrl0_s;

    typedef struct packed {
        logic [1:0] supply_fail_flags;
        logic [1:0] thermal_shutdown_flags;
        logic thermal_warning_flag;
        logic overvoltage_flag;
        logic undervoltage_flag;
        logic [3:0] small_driver_overcurrent;
        logic main_driver_overcurrent;
        logic [1:0] relay_overcurrent;
        logic reg_two_overcurrent;
    } smdcr_fault_s;

endpackage

// file: tb/smdcr_regs_checker.sv
// concurrent checks on the serial control register block ports
`timescale 1ns/100ps
module smdcr_regs_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chip_select_low,
    input wire logic data_out_oe,
    input wire smdcr_pkg::smdcr_ctrl0_s driver_regulator_control,
    input wire smdcr_pkg::smdcr_mode_e op_mode,
    input wire logic main_highside_on,
    input wire logic [1:0] relay_on,
    input wire logic reg_two_on,
    input wire logic [11:0] small_highside_config,
    input wire logic watchdog_trigger
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // drivers lag the control word and mode by one edge
    smdcr_pkg::smdcr_ctrl0_s ctrl_q;
    smdcr_pkg::smdcr_mode_e mode_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= smdcr_pkg::CTRL_RESET;
            mode_q <= smdcr_pkg::MODE_ACTIVE;
        end else begin
            ctrl_q <= driver_regulator_control;
            mode_q <= op_mode;
        end
    end
    wire logic act = (mode_q == smdcr_pkg::MODE_ACTIVE);
    wire logic [1:0] r2 = {ctrl_q.reg_two_mode_hi, ctrl_q.reg_two_mode_lo};
    a_oe_tracks_cs: assert property (data_out_oe == !chip_select_low)
        else $error("data out enable not tied to frame select");
    a_reset_clears: assert property ($fell(rst) |->
        driver_regulator_control == smdcr_pkg::CTRL_RESET && !watchdog_trigger)
        else $error("control word not clear after reset");
    a_write_at_rise: assert property ($changed(driver_regulator_control) |->
        chip_select_low && $past(chip_select_low, 2))
        else $error("control word changed inside a frame");
    a_small_cfg_copy: assert property ($changed(driver_regulator_control.small_highside_config)
        |-> ##[0:1] small_highside_config == driver_regulator_control.small_highside_config)
        else $error("small driver config not copied");
    a_watchdog_toggle_on_toggle: assert property (
        watchdog_trigger == $changed(driver_regulator_control.watchdog_toggle))
        else $error("trigger not matched to toggle change");
    a_watchdog_toggle_one_cycle: assert property (watchdog_trigger |=> !watchdog_trigger)
        else $error("trigger longer than one cycle");
    a_relay_active: assert property (
        relay_on == (act ? {ctrl_q.relay_b_enable, ctrl_q.relay_a_enable} : 2'h0))
        else $error("relay output wrong for mode");
    a_reg_two_mode: assert property (reg_two_on == (r2 == smdcr_pkg::REG2_ALWAYS ||
        (r2 != smdcr_pkg::REG2_OFF && act) ||
        (r2 == smdcr_pkg::REG2_ACT_STBY1 && mode_q == smdcr_pkg::MODE_REG1_STANDBY)))
        else $error("regulator two output wrong for mode");
    a_main_off_code: assert property (ctrl_q.main_highside_config == smdcr_pkg::HS_OFF
        |-> !main_highside_on)
        else $error("main driver on under off code");
    a_main_active: assert property (ctrl_q.main_highside_config == smdcr_pkg::HS_ACTIVE
        |-> main_highside_on == act)
        else $error("main driver wrong under active code");
    c_trigger: cover property (watchdog_trigger);
    c_bat: cover property (op_mode == smdcr_pkg::MODE_BAT_STANDBY);
    c_reg1: cover property (op_mode == smdcr_pkg::MODE_REG1_STANDBY);
endmodule

// file: tb/smdcr_host_model.sv
// serial master model: frames of 0 to 25 bits, link clock still between frames
`timescale 1ns/100ps
module smdcr_host_model (
    output logic spi_clk,
    output logic chip_select_low,
    output logic data_in,
    input wire logic data_out
);
    logic [24:0] last_rx = '0;
    event done;
    initial begin
        spi_clk = 1'b0;
        chip_select_low = 1'b1;
        data_in = 1'b0;
    end
    task automatic frame(input logic [24:0] tx, input int n, output logic [24:0] rx);
        rx = '0;
        chip_select_low = 1'b0;
        #400;
        for (int i = n - 1; i >= 0; i--) begin
            data_in = tx[i];
            #15 spi_clk = 1'b1;
            rx = {rx[23:0], data_out};
            #15 spi_clk = 1'b0;
        end
        #400 chip_select_low = 1'b1;
        // a released line must not keep showing the last bit
        data_in = ~data_in;
        last_rx = rx;
        if (n == 24) -> done;
        #6000;
    endtask
endmodule

// file: tb/smdcr_regs_test.sv
// self-checking bench for the serial control register block
`timescale 1ns/100ps
module smdcr_regs_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic spi_clk, chip_select_low, data_in, data_out, data_out_oe;
    smdcr_pkg::smdcr_fault_s fault_flags = '0;
    logic [21:0] fault_wakeup_status = '0;
    logic [21:0] link_watchdog_status = '0;
    logic wake_event = 1'b0;
    logic cyclic_timer_a = 1'b0;
    logic cyclic_timer_b = 1'b0;
    logic pulse_input_a = 1'b0;
    logic pulse_input_b = 1'b0;
    smdcr_pkg::smdcr_ctrl0_s driver_regulator_control;
    smdcr_pkg::smdcr_mode_e op_mode;
    logic [21:0] wake_timer_control, input_config_control, d;
    logic [21:0] e0 = '0;
    logic [21:0] e1 = '0;
    logic [21:0] e2 = '0;
    logic main_highside_on, reg_two_on, watchdog_trigger;
    logic wd_prev = 1'b0;
    logic [1:0] relay_on;
    logic [11:0] small_highside_config;
    logic [23:0] exp_q[$];
    logic [24:0] rx;
    int n_errors = 0;
    int comparisons = 0;
    int n_watchdog_toggle = 0;
    int exp_watchdog_toggle = 0;
    integer seed = 32'h7E76;
    smdcr_regs u_dut (.core_clk(core_clk), .rst(rst), .spi_clk(spi_clk),
        .chip_select_low(chip_select_low), .data_in(data_in), .data_out(data_out),
        .data_out_oe(data_out_oe), .fault_flags(fault_flags),
        .fault_wakeup_status(fault_wakeup_status), .link_watchdog_status(link_watchdog_status),
        .wake_event(wake_event), .cyclic_timer_a(cyclic_timer_a), .cyclic_timer_b(cyclic_timer_b),
        .pulse_input_a(pulse_input_a), .pulse_input_b(pulse_input_b),
        .driver_regulator_control(driver_regulator_control),
        .wake_timer_control(wake_timer_control), .input_config_control(input_config_control),
        .op_mode(op_mode), .main_highside_on(main_highside_on), .relay_on(relay_on),
        .reg_two_on(reg_two_on), .small_highside_config(small_highside_config),
        .watchdog_trigger(watchdog_trigger));
    smdcr_host_model u_host (.spi_clk(spi_clk), .chip_select_low(chip_select_low),
        .data_in(data_in), .data_out(data_out));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic exp_hs(input logic [2:0] c);
        case (c)
            smdcr_pkg::HS_ACTIVE: return 1'b1;
            smdcr_pkg::HS_TIMER_A: return cyclic_timer_a;
            smdcr_pkg::HS_TIMER_B: return cyclic_timer_b;
            smdcr_pkg::HS_PULSE_A: return pulse_input_a;
            smdcr_pkg::HS_PULSE_B: return pulse_input_b;
            default: return 1'b0;
        endcase
    endfunction
    task automatic wr(input logic [1:0] a, input logic [21:0] v);
        logic [21:0] st;
        st = (a == smdcr_pkg::ADDR_CTRL0) ? fault_wakeup_status :
            (a == smdcr_pkg::ADDR_CTRL1) ? link_watchdog_status : smdcr_pkg::WORD_ZERO;
        exp_q.push_back({{2{|fault_flags}}, st});
        if (a == smdcr_pkg::ADDR_CTRL0 && v[19] !== wd_prev) begin
            exp_watchdog_toggle++;
            wd_prev = v[19];
        end
        u_host.frame({1'b0, a, v}, 24, rx);
    endtask
    task automatic stby(input logic [21:0] v, input smdcr_pkg::smdcr_mode_e m, input logic r);
        wr(smdcr_pkg::ADDR_CTRL0, v);
        check("mode", op_mode, m);
        check("reg two", reg_two_on, r);
        check("relays", relay_on, 2'h0);
        check("main driver", main_highside_on, 1'b0);
        @(posedge core_clk);
        wake_event <= 1'b1;
        @(posedge core_clk);
        wake_event <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("woken", op_mode, smdcr_pkg::MODE_ACTIVE);
    endtask
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (watchdog_trigger === 1'b1) n_watchdog_toggle++;
    end
    always @(u_host.done) begin
        if (exp_q.size() == 0) begin
            check("frame count", 24'h1, 24'h0);
        end else begin
            check("frame out", u_host.last_rx[23:0], exp_q.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        check("timeout", 24'h1, 24'h0);
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("ctrl0 reset", driver_regulator_control, 24'h0);
        check("ctrl1 ctrl2 reset", wake_timer_control | input_config_control, 24'h0);
        // one pass per fault flag, the last with none raised
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            fault_flags <= (i < 15) ? 15'h1 << i : 15'h0;
            fault_wakeup_status <= 22'($random(seed));
            link_watchdog_status <= 22'($random(seed));
            {cyclic_timer_a, cyclic_timer_b, pulse_input_a, pulse_input_b} <= 4'($random(seed));
            d = 22'($random(seed));
            d[21:20] = 2'h0;
            d[14:12] = 3'(i % 6);
            repeat (4) @(posedge core_clk);
            wr(smdcr_pkg::ADDR_CTRL0, d);
            e0 = d;
            check("ctrl0", driver_regulator_control, d);
            check("small cfg", small_highside_config, d[11:0]);
            check("main driver", main_highside_on, exp_hs(d[14:12]));
            check("relays", relay_on, d[16:15]);
            check("reg two", reg_two_on, |d[18:17]);
        end
        for (int a = 1; a < 4; a++) begin
            d = 22'($random(seed));
            wr(2'(a), d);
            if (a == 1) e1 = d;
            if (a == 2) e2 = d;
            check("ctrl1", wake_timer_control, e1);
            check("ctrl2", input_config_control, e2);
            check("ctrl0 kept", driver_regulator_control, e0);
        end
        u_host.frame(25'h1FFFFF, 23, rx);
        u_host.frame(25'h7FFFFF, 25, rx);
        check("ctrl0 odd frames", driver_regulator_control, e0);
        stby(22'h379000, smdcr_pkg::MODE_BAT_STANDBY, 1'b1);
        stby(22'h259000, smdcr_pkg::MODE_REG1_STANDBY, 1'b1);
        stby(22'h159000, smdcr_pkg::MODE_BAT_STANDBY, 1'b0);
        // select pulse with no clock must not replay the standby write above
        u_host.frame(25'h0, 0, rx);
        check("bare select", op_mode, smdcr_pkg::MODE_ACTIVE);
        check("trigger count", 24'(n_watchdog_toggle), 24'(exp_watchdog_toggle));
        check("frames left", 24'(exp_q.size()), 24'h0);
        tally_and_finish();
    end
endmodule
bind smdcr_regs smdcr_regs_checker u_chk (.core_clk(core_clk), .rst(rst),
    .chip_select_low(chip_select_low), .data_out_oe(data_out_oe),
    .driver_regulator_control(driver_regulator_control), .op_mode(op_mode),
    .main_highside_on(main_highside_on), .relay_on(relay_on), .reg_two_on(reg_two_on),
    .small_highside_config(small_highside_config), .watchdog_trigger(watchdog_trigger));
